// ### pcs_pkg.sv
// Purpose: Shared constants for the PLL clock select register block
// Assumes: APB slave with 32-bit data, each register one aligned word
// Notes:   Byte address of a register is four times its index
`default_nettype none

package pcs_pkg;

    // Register indices; byte address is index times four
    localparam logic [31:0] GUARD_INDEX   = 32'hFFFF_F822;
    localparam logic [31:0] SELECT_INDEX  = 32'hFFFF_F824;
    localparam logic [31:0] DIVIDE_INDEX  = 32'hFFFF_F828;
    localparam logic [31:0] UNLOCK_INDEX  = 32'hFFFF_F800;
    localparam logic [31:0] BITOP_INDEX   = 32'hFFFF_F804;
    localparam logic [31:0] STATUS_INDEX  = 32'hFFFF_F830;

    // Reset values
    localparam logic [7:0] SELECT_RESET   = 8'h01;
    localparam logic [7:0] GUARD_RESET    = 8'h0A;
    localparam logic [7:0] DIVIDE_RESET   = 8'h03;

    // Guard register layout
    localparam logic [7:0] GUARD_FIXED    = 8'h08;
    localparam logic [7:0] GUARD_WMASK    = 8'h03;
    localparam logic [7:0] GUARD_REQUIRED = 8'h0B;

    // Mode select register layout
    localparam int         CHOICE_BIT     = 1;
    localparam logic [7:0] SELECT_FIXED   = 8'h01;

    // Unlock key written before a protected write
    localparam logic [7:0] UNLOCK_KEY     = 8'hA5;

    // Bit operation register fields
    localparam int         BITOP_TGT_LSB  = 0;
    localparam int         BITOP_NUM_LSB  = 2;
    localparam int         BITOP_OP_LSB   = 5;
    localparam logic       TGT_SELECT     = 1'b0;
    localparam logic       TGT_DIVIDE     = 1'b1;
    localparam logic [1:0] OP_SET         = 2'h1;
    localparam logic [1:0] OP_CLEAR       = 2'h2;
    localparam logic [1:0] OP_INVERT      = 2'h3;

    // Status register bits
    localparam int         STS_PROT_ERR   = 0;
    localparam int         STS_NO_GUARD   = 1;
    localparam int         STS_ARMED      = 2;

    // Clock multiplication factors
    localparam logic [3:0] FACTOR_PLL     = 4'h8;
    localparam logic [3:0] FACTOR_THROUGH = 4'h1;

endpackage

`default_nettype wire

// ### pcs_protect_gate.sv
// Purpose: Unlock sequencer for protected register writes
// Assumes: Pulses come from completed bus writes on the same clock
// Notes:   Any mapped write with byte lane 0 strobed, other than a correct key write, drops the unlock
`default_nettype none

module pcs_protect_gate (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic unlockWrite,
    input  wire logic anyWrite,
    input  wire logic protectedWrite,
    output logic      armed,
    output logic      grant,
    output logic      violation
);

    // Armed after the key; the next anyWrite pulse that is not a key write consumes or cancels it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (unlockWrite) begin
            armed <= 1'b1;
        end else if (anyWrite) begin
            armed <= 1'b0;
        end
    end

    // Protected write passes only as the first counted write after the key
    assign grant     = armed & protectedWrite;
    assign violation = ~armed & protectedWrite;

endmodule // pcs_protect_gate

`default_nettype wire

// ### pcs_clock_select.sv
// Purpose: Clock mode select, guard and processor clock registers over APB
// Assumes: Single clock; APB master holds request until pready
// Notes:   One wait state on every access; bit access via bit-op register
// Function
// - The mode select register chooses the CPU clock source and allows byte and single-bit access.
// - Reset loads the mode select register with 01H, selecting clock-through operation.
// - Bit 1 of the mode select register set selects the multiplied clock, clear passes the oscillator through.
// - The guard register changes only when written through the protected sequence.
// - The guard register allows byte access only, with no single-bit access.
// - Reset loads the guard register with 0AH; bit 3 is fixed high, bits 1 and 0 are writable, others zero.
// - The processor clock register changes only through the protected sequence, by byte or single bit.
// - Reset loads the processor clock register with 03H.
// - The delivered clock is the oscillator times eight in multiplied mode and unchanged otherwise.
`default_nettype none

module pcs_clock_select (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             multipliedClockChoice,
    output logic [3:0]       clockFactor,
    output logic [7:0]       guardValue,
    output logic [7:0]       processorClockDivide
);

    // Register storage
    logic       choice;
    logic [7:0] guard;
    logic [7:0] divide;
    logic       protErr;
    logic       noGuard;

    // Address decode on word index
    logic       hitGuard;
    logic       hitSelect;
    logic       hitDivide;
    logic       hitUnlock;
    logic       hitBitop;
    logic       hitStatus;
    logic       mapped;

    // Transfer control
    logic       accessDone;
    logic       writeDone;
    logic       lane0;

    // Bit operation decode
    logic       bitopTarget;
    logic [2:0] bitopNum;
    logic [1:0] bitopOp;
    logic [7:0] bitopMask;
    logic [7:0] selectImage;
    logic [7:0] selectBitop;
    logic [7:0] divideBitop;

    // Protection
    logic       unlockWrite;
    logic       protectedWrite;
    logic       armed;
    logic       grant;
    logic       violation;
    logic       divideByte;
    logic       divideBit;
    logic       guardByte;

    // Next values
    logic [31:0] next_prdata;
    logic        next_choice;

    assign hitGuard  = (paddr[31:2] == pcs_pkg::GUARD_INDEX[29:0]);
    assign hitSelect = (paddr[31:2] == pcs_pkg::SELECT_INDEX[29:0]);
    assign hitDivide = (paddr[31:2] == pcs_pkg::DIVIDE_INDEX[29:0]);
    assign hitUnlock = (paddr[31:2] == pcs_pkg::UNLOCK_INDEX[29:0]);
    assign hitBitop  = (paddr[31:2] == pcs_pkg::BITOP_INDEX[29:0]);
    assign hitStatus = (paddr[31:2] == pcs_pkg::STATUS_INDEX[29:0]);
    assign mapped    = hitGuard | hitSelect | hitDivide | hitUnlock | hitBitop | hitStatus;

    // Completion edge: access phase with pready already high
    assign accessDone = psel & penable & pready;
    assign lane0      = pstrb[0];
    assign writeDone  = accessDone & pwrite & mapped & lane0;

    // Bit operation fields
    assign bitopTarget = pwdata[pcs_pkg::BITOP_TGT_LSB];
    assign bitopNum    = pwdata[pcs_pkg::BITOP_NUM_LSB +: 3];
    assign bitopOp     = pwdata[pcs_pkg::BITOP_OP_LSB +: 2];
    assign bitopMask   = 8'(8'h01 << bitopNum);

    // Visible image of the mode select register
    assign selectImage = pcs_pkg::SELECT_FIXED
                       | (8'(choice) << pcs_pkg::CHOICE_BIT);

    // Apply one bit operation to a byte image
    function automatic logic [7:0] apply_bitop(input logic [7:0] value,
                                               input logic [7:0] mask,
                                               input logic [1:0] op);
        logic [7:0] result;
        result = value;
        case (op)
            pcs_pkg::OP_SET: begin
                result = value | mask;
            end
            pcs_pkg::OP_CLEAR: begin
                result = value & ~mask;
            end
            pcs_pkg::OP_INVERT: begin
                result = value ^ mask;
            end
            default: begin
                result = value;
            end
        endcase
        return result;
    endfunction

    assign selectBitop = apply_bitop(selectImage, bitopMask, bitopOp);
    assign divideBitop = apply_bitop(divide, bitopMask, bitopOp);

    // Protected write classification
    assign unlockWrite = writeDone & hitUnlock & (pwdata[7:0] == pcs_pkg::UNLOCK_KEY);
    assign guardByte   = writeDone & hitGuard;
    assign divideByte  = writeDone & hitDivide;
    assign divideBit   = writeDone & hitBitop & (bitopTarget == pcs_pkg::TGT_DIVIDE);
    assign protectedWrite = guardByte | divideByte | divideBit;

    pcs_protect_gate protectGate (
        .clk            (clk),
        .nrst           (nrst),
        .unlockWrite    (unlockWrite),
        .anyWrite       (writeDone),
        .protectedWrite (protectedWrite),
        .armed          (armed),
        .grant          (grant),
        .violation      (violation)
    );

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // Read data mux
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hitSelect) begin
            next_prdata[7:0] = selectImage;
        end else if (hitGuard) begin
            next_prdata[7:0] = guard;
        end else if (hitDivide) begin
            next_prdata[7:0] = divide;
        end else if (hitStatus) begin
            next_prdata[pcs_pkg::STS_PROT_ERR] = protErr;
            next_prdata[pcs_pkg::STS_NO_GUARD] = noGuard;
            next_prdata[pcs_pkg::STS_ARMED]    = armed;
        end
    end

    // Read data and error answer, loaded with pready
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= ~mapped;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Mode select next value: byte write or bit operation
    always_comb begin
        next_choice = choice;
        if (writeDone & hitSelect) begin
            next_choice = pwdata[pcs_pkg::CHOICE_BIT];
        end else if (writeDone & hitBitop & (bitopTarget == pcs_pkg::TGT_SELECT)) begin
            next_choice = selectBitop[pcs_pkg::CHOICE_BIT];
        end
    end

    // Mode select bit; clear after reset gives clock-through
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            choice <= pcs_pkg::SELECT_RESET[pcs_pkg::CHOICE_BIT];
        end else begin
            choice <= next_choice;
        end
    end

    // Guard register: protected byte write, fixed bits forced
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            guard <= pcs_pkg::GUARD_RESET;
        end else if (grant & guardByte) begin
            guard <= pcs_pkg::GUARD_FIXED | (pwdata[7:0] & pcs_pkg::GUARD_WMASK);
        end
    end

    // Processor clock register: protected byte or bit write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divide <= pcs_pkg::DIVIDE_RESET;
        end else if (grant & divideByte) begin
            divide <= pwdata[7:0];
        end else if (grant & divideBit) begin
            divide <= divideBitop;
        end
    end

    // Sticky protection error; a new violation beats the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            protErr <= 1'b0;
        end else if (violation) begin
            protErr <= 1'b1;
        end else if (writeDone & hitStatus & pwdata[pcs_pkg::STS_PROT_ERR]) begin
            protErr <= 1'b0;
        end
    end

    // Sticky flag: multiplied clock chosen without the required guard
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            noGuard <= 1'b0;
        end else if (next_choice & ~choice & (guard != pcs_pkg::GUARD_REQUIRED)) begin
            noGuard <= 1'b1;
        end else if (writeDone & hitStatus & pwdata[pcs_pkg::STS_NO_GUARD]) begin
            noGuard <= 1'b0;
        end
    end

    // Clock mode outputs to the clock tree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            multipliedClockChoice <= 1'b0;
            clockFactor           <= pcs_pkg::FACTOR_THROUGH;
        end else begin
            multipliedClockChoice <= choice;
            clockFactor           <= choice ? pcs_pkg::FACTOR_PLL
                                            : pcs_pkg::FACTOR_THROUGH;
        end
    end

    // Register copies for the clock tree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            guardValue           <= pcs_pkg::GUARD_RESET;
            processorClockDivide <= pcs_pkg::DIVIDE_RESET;
        end else begin
            guardValue           <= guard;
            processorClockDivide <= divide;
        end
    end

endmodule // pcs_clock_select

`default_nettype wire

// ### pcs_clock_select_chk.sv
// Purpose: Port checker for the clock select register block
// Assumes: APB slave with one wait state, copies one cycle behind
// Notes:   Attached to the design by bind
`default_nettype none

module pcs_clock_select_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        multipliedClockChoice,
    input wire logic [3:0]  clockFactor,
    input wire logic [7:0]  guardValue,
    input wire logic [7:0]  processorClockDivide
);
    localparam logic [31:0] SEL_ADDR = pcs_pkg::SELECT_INDEX << 2;
    localparam logic [31:0] GRD_ADDR = pcs_pkg::GUARD_INDEX << 2;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Bus timing and read data shape
    property p_ready_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    property p_sel_read;
        pready && !pwrite && paddr == SEL_ADDR |-> prdata[7:2] == 6'h0 && prdata[0] && !pslverr;
    endproperty
    // Register copies change only after a completed write
    property p_guard_hold;
        $changed(guardValue) |-> $past(pready && pwrite, 2);
    endproperty
    property p_div_hold;
        $changed(processorClockDivide) |-> $past(pready && pwrite, 2);
    endproperty
    property p_choice_hold;
        $changed(multipliedClockChoice) |-> $past(pready && pwrite, 2);
    endproperty
    property p_guard_fixed;
        (guardValue & ~pcs_pkg::GUARD_WMASK) == pcs_pkg::GUARD_FIXED;
    endproperty
    property p_factor;
        $stable(multipliedClockChoice) |->
            clockFactor == (multipliedClockChoice ? pcs_pkg::FACTOR_PLL : pcs_pkg::FACTOR_THROUGH);
    endproperty

    a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait state");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
    a_upper_zero: assert property (p_upper_zero) else $error("prdata upper bits set");
    a_sel_read: assert property (p_sel_read) else $error("mode select fixed bits wrong");
    a_guard_hold: assert property (p_guard_hold) else $error("guard changed without write");
    a_div_hold: assert property (p_div_hold) else $error("divide changed without write");
    a_choice_hold: assert property (p_choice_hold) else $error("choice changed without write");
    a_guard_fixed: assert property (p_guard_fixed) else $error("guard fixed bits wrong");
    a_factor: assert property (p_factor) else $error("clock factor mismatch");

    c_guard_write: cover property (pready && pwrite && paddr == GRD_ADDR);
    c_pll_on: cover property ($rose(multipliedClockChoice));
    c_bus_err: cover property (pready && pslverr);
endmodule // pcs_clock_select_chk

bind pcs_clock_select pcs_clock_select_chk u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .multipliedClockChoice(multipliedClockChoice), .clockFactor(clockFactor),
    .guardValue(guardValue), .processorClockDivide(processorClockDivide));

`default_nettype wire

// ### test_pll_clock_select_regs.sv
// Purpose: Self-checking bench for the clock select register block
// Assumes: APB master waits for pready, idle cycle between transfers
// Notes:   Table of register accesses, then hand-written cases
`default_nettype none

module test_pll_clock_select_regs;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic wr; logic [31:0] idx; logic [7:0] val;} pcs_row_t;
    localparam pcs_row_t ROWS [0:19] = '{
        '{1'h0, pcs_pkg::GUARD_INDEX, 8'h0A}, '{1'h0, pcs_pkg::SELECT_INDEX, 8'h01},
        '{1'h0, pcs_pkg::DIVIDE_INDEX, 8'h03}, '{1'h1, pcs_pkg::GUARD_INDEX, 8'h0B},
        '{1'h0, pcs_pkg::GUARD_INDEX, 8'h0A}, '{1'h1, pcs_pkg::UNLOCK_INDEX, 8'hA5},
        '{1'h1, pcs_pkg::GUARD_INDEX, 8'hFF}, '{1'h0, pcs_pkg::GUARD_INDEX, 8'h0B},
        '{1'h1, pcs_pkg::SELECT_INDEX, 8'hFE}, '{1'h0, pcs_pkg::SELECT_INDEX, 8'h03},
        '{1'h1, pcs_pkg::UNLOCK_INDEX, 8'hA5}, '{1'h1, pcs_pkg::DIVIDE_INDEX, 8'h00},
        '{1'h0, pcs_pkg::DIVIDE_INDEX, 8'h00}, '{1'h1, pcs_pkg::DIVIDE_INDEX, 8'h02},
        '{1'h0, pcs_pkg::DIVIDE_INDEX, 8'h00}, '{1'h1, pcs_pkg::UNLOCK_INDEX, 8'hA5},
        '{1'h1, pcs_pkg::BITOP_INDEX, 8'h25}, '{1'h0, pcs_pkg::DIVIDE_INDEX, 8'h02},
        '{1'h1, pcs_pkg::BITOP_INDEX, 8'h64}, '{1'h0, pcs_pkg::SELECT_INDEX, 8'h01}};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        multipliedClockChoice;
    logic [3:0]  clockFactor;
    logic [7:0]  guardValue;
    logic [7:0]  processorClockDivide;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          num_checks = 0;

    // Clock at 125 MHz
    always #4 clk = ~clk;

    pcs_clock_select u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .multipliedClockChoice(multipliedClockChoice), .clockFactor(clockFactor), .guardValue(guardValue),
        .processorClockDivide(processorClockDivide));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] idx, input logic [7:0] d, input logic [3:0] strb);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= idx << 2;
        pwdata <= {24'h00_0000, d};
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) check("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        foreach (ROWS[i]) begin
            apb(ROWS[i].wr, ROWS[i].idx, ROWS[i].wr ? ROWS[i].val : 8'h00, 4'hF);
            if (!ROWS[i].wr) check("table read", rd, {24'h00_0000, ROWS[i].val});
        end
        $display("test table done");
        apb(1'b1, pcs_pkg::BITOP_INDEX, 8'h24, 4'hF);
        repeat (3) @(posedge clk);
        check("choice", multipliedClockChoice, 1'b1);
        check("factor", clockFactor, pcs_pkg::FACTOR_PLL);
        check("guard copy", guardValue, 8'h0B);
        check("divide copy", processorClockDivide, 8'h02);
        $display("test ports done");
        apb(1'b0, 32'h0000_0100, 8'h00, 4'hF);
        check("unmapped err", err, 1'b1);
        apb(1'b1, pcs_pkg::UNLOCK_INDEX, 8'hA5, 4'hF);
        apb(1'b1, pcs_pkg::GUARD_INDEX, 8'h00, 4'h0);
        apb(1'b1, pcs_pkg::GUARD_INDEX, 8'h00, 4'hF);
        apb(1'b0, pcs_pkg::GUARD_INDEX, 8'h00, 4'hF);
        check("guard strobe", rd, 32'h0000_0008);
        apb(1'b0, pcs_pkg::STATUS_INDEX, 8'h00, 4'hF);
        check("status violation", rd, 32'h0000_0001);
        apb(1'b1, pcs_pkg::STATUS_INDEX, 8'h01, 4'hF);
        apb(1'b0, pcs_pkg::STATUS_INDEX, 8'h00, 4'hF);
        check("status cleared", rd, 32'h0000_0000);
        $display("test refusals done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        check("reset guard", guardValue, 8'h0A);
        check("reset divide", processorClockDivide, 8'h03);
        check("reset factor", clockFactor, pcs_pkg::FACTOR_THROUGH);
        nrst <= 1'b1;
        apb(1'b0, pcs_pkg::SELECT_INDEX, 8'h00, 4'hF);
        check("reset select", rd, 32'h0000_0001);
        $display("test reset done");
        // Multiplied clock chosen with the guard still at its reset value
        apb(1'b1, pcs_pkg::SELECT_INDEX, 8'h02, 4'hF);
        apb(1'b0, pcs_pkg::STATUS_INDEX, 8'h00, 4'hF);
        check("status unguarded", rd, 32'h0000_0002);
        check("choice unguarded", multipliedClockChoice, 1'b1);
        // A read leaves the unlock armed; bit clear on the processor clock register
        apb(1'b1, pcs_pkg::UNLOCK_INDEX, 8'hA5, 4'hF);
        apb(1'b0, pcs_pkg::STATUS_INDEX, 8'h00, 4'hF);
        check("status armed", rd, 32'h0000_0006);
        apb(1'b1, pcs_pkg::BITOP_INDEX, 8'h45, 4'hF);
        apb(1'b0, pcs_pkg::DIVIDE_INDEX, 8'h00, 4'hF);
        check("divide bit clear", rd, 32'h0000_0001);
        // Wrong key does not unlock
        apb(1'b1, pcs_pkg::UNLOCK_INDEX, 8'h5A, 4'hF);
        apb(1'b1, pcs_pkg::DIVIDE_INDEX, 8'h00, 4'hF);
        apb(1'b0, pcs_pkg::DIVIDE_INDEX, 8'h00, 4'hF);
        check("divide wrong key", rd, 32'h0000_0001);
        apb(1'b0, pcs_pkg::STATUS_INDEX, 8'h00, 4'hF);
        check("status wrong key", rd, 32'h0000_0003);
        apb(1'b1, pcs_pkg::STATUS_INDEX, 8'h03, 4'hF);
        apb(1'b0, pcs_pkg::STATUS_INDEX, 8'h00, 4'hF);
        check("status both cleared", rd, 32'h0000_0000);
        $display("test status done");
        print_verdict();
    end
endmodule // test_pll_clock_select_regs

`default_nettype wire
